// [logic/adc_seq_pkg.sv]
package adc_seq_pkg;

    // ==================================================================
    // register map (byte addresses, each register one aligned word)
    // ==================================================================
    localparam logic [7:0] SEQ_CTRL_INDEX   = 8'h03;
    localparam logic [7:0] SEQ_CTRL_ADDR    = 8'h0C;
    localparam logic [7:0] START_ADDR       = 8'h14;
    localparam logic [7:0] CONV_STATUS_ADDR = 8'h18;
    localparam logic [7:0] CCF_ADDR         = 8'h1C;
    localparam logic [7:0] OPTIONS_ADDR     = 8'h20;
    localparam logic [7:0] IRQ_STATUS_ADDR  = 8'h24;
    localparam logic [7:0] IRQ_MASK_ADDR    = 8'h28;
    localparam logic [7:0] RESULT_BASE_ADDR = 8'h40;

    // ==================================================================
    // sequence control fields
    // ==================================================================
    localparam int         LEN_MSB          = 6;
    localparam int         LEN_LSB          = 3;
    localparam int         QUEUE_BIT        = 2;
    localparam int         FREEZE_MSB       = 1;
    localparam int         FREEZE_LSB       = 0;
    localparam logic [7:0] SEQ_CTRL_RESET   = 8'h20;
    localparam logic [7:0] SEQ_CTRL_WMASK   = 8'h7F;

    // options register fields
    localparam int         SCAN_BIT         = 0;
    localparam int         FAST_CLEAR_BIT   = 1;

    // irq status fields
    localparam int         IRQ_SEQ_DONE     = 0;
    localparam int         IRQ_ABORT        = 1;
    localparam int         IRQ_WIDTH        = 2;

    // freeze encodings
    localparam logic [1:0] FREEZE_CONTINUE  = 2'h0;
    localparam logic [1:0] FREEZE_FINISH    = 2'h2;
    localparam logic [1:0] FREEZE_NOW       = 2'h3;

    // result file and conversion timing
    localparam int         NUM_RESULTS      = 8;
    localparam int         RESULT_WIDTH     = 10;
    localparam int         CONV_TIME_NS     = 1400;
    localparam int         CLK_PERIOD_NS    = 100;
    localparam logic [4:0] CONV_CYCLES      = 5'((CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // AHB-Lite codes
    localparam logic [1:0] HTRANS_NONSEQ    = 2'h2;
    localparam logic [1:0] HTRANS_SEQ       = 2'h3;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_CONV   = 3'b010,
        ST_FROZEN = 3'b100
    } seq_state_t;

endpackage

// [logic/seq_len_decode.sv]
`timescale 1ns/1ns
module seq_len_decode
    import adc_seq_pkg::*;
(
    // length field in, count out
    input  wire logic [3:0] len_field,
    output logic      [3:0] len_count
);
    // ==================================================================
    // length coding
    // ==================================================================
    // zero and any value with the top bit set mean eight conversions
    always_comb begin
        if (len_field[3] || len_field == 4'h0) begin
            len_count = 4'h8;
        end else begin
            len_count = len_field;
        end
    end
endmodule

// [logic/conv_timer.sv]
`timescale 1ns/1ns
module conv_timer
    import adc_seq_pkg::*;
(
    // clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // control
    input  wire logic start,
    input  wire logic hold,
    input  wire logic cancel,
    output logic      done
);
    // ==================================================================
    // conversion timer
    // ==================================================================
    logic [4:0] remain;
    logic       busy;

    // hold stops the count in place so a frozen conversion resumes later
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            remain <= 5'h00;
            busy   <= 1'b0;
            done   <= 1'b0;
        end else begin
            done <= 1'b0;
            if (cancel) begin
                busy <= 1'b0;
            end else if (start) begin
                remain <= CONV_CYCLES;
                busy   <= 1'b1;
            end else if (busy && !hold) begin
                if (remain == 5'h01) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
                remain <= remain - 5'h01;
            end
        end
    end
endmodule

// [logic/adc_sequence_control.sv]
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/1ns
// Notes on behaviour
// - A write to the sequence control register stops any running sequence and does not start another.
// - Software may read and write the sequence control register at any time.
// - Length field bits 6..3: zero gives eight, one to seven give that count, top bit set gives eight.
// - After reset the length field selects four conversions.
// - With queue mode off, each result goes to the register matching its place in the sequence.
// - With queue mode on, the counter is reset at sequence start but not at sequence end.
// - In queue mode with scanning, the counter wraps from the last result register to the first.
// - The conversion counter is readable in a status register.
// - Aborting through a control write, or starting through a start write, clears the counter even in queue mode.
// - Each result register has a completion flag showing it holds valid data.
// - Freeze field bits 1..0: 00 keep going, 01 reserved, 10 finish then freeze, 11 freeze at once.
// - With fast clear on, any access to a result register clears its completion flag.
module adc_sequence_control
    import adc_seq_pkg::*;
(
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // converter side
    input  wire logic        debug_freeze,
    input  wire logic [9:0]  sample_data,
    output logic             converting,
    output logic      [2:0]  sample_channel,
    output logic             irq
);
    // ==================================================================
    // declarations
    // ==================================================================
    // software-visible state
    logic [7:0]              seq_ctrl;
    logic                    scan_mode;
    logic                    fast_clear;
    logic [IRQ_WIDTH-1:0]    irq_status;
    logic [IRQ_WIDTH-1:0]    irq_mask;
    logic [RESULT_WIDTH-1:0] results [NUM_RESULTS];
    logic [NUM_RESULTS-1:0]  ccf;
    logic [2:0]              conversion_counter;
    logic [3:0]              seq_pos;
    logic [3:0]              len_count;
    seq_state_t              state;
    // bus data phase
    logic                    dp_write;
    logic                    dp_read;
    logic [7:0]              dp_addr;
    logic                    ctrl_write;
    logic                    start_write;
    // conversion control
    logic                    conv_done;
    logic                    conv_start;
    logic                    conv_hold;
    // freeze handling, sequence end, bus and fast clear decode
    logic                    freeze_sync1;
    logic                    freeze_sync2;
    logic                    freeze_req;
    logic                    seq_last;
    logic                    access_now;
    logic [31:0]             next_rdata;
    logic                    seq_end;
    logic                    result_access;

    // result word decode, used for both read and fast clear
    function automatic logic is_result(input logic [7:0] a);
        return a[7:5] == RESULT_BASE_ADDR[7:5] && a[1:0] == 2'h0;
    endfunction

    // ==================================================================
    // bus slave
    // ==================================================================
    assign access_now  = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
    assign ctrl_write  = dp_write && dp_addr == SEQ_CTRL_ADDR;
    assign start_write = dp_write && dp_addr == START_ADDR;

    // hsize is not decoded: every register is one aligned word
    // zero wait state slave, always OKAY; reads register their data here
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write  <= 1'b0;
            dp_read   <= 1'b0;
            dp_addr   <= 8'h00;
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            dp_write <= access_now && hwrite;
            dp_read  <= access_now && !hwrite;
            dp_addr  <= haddr;
            if (access_now && !hwrite) begin
                hrdata <= next_rdata;
            end
        end
    end

    // read mux; unmapped words read zero
    // every register reads back at any time, whatever the converter does
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (is_result(haddr)) begin
            next_rdata = {22'h000000, results[haddr[4:2]]};
        end else begin
            case (haddr)
                SEQ_CTRL_ADDR:    next_rdata = {24'h000000, seq_ctrl};
                CONV_STATUS_ADDR: next_rdata = {25'h0000000, seq_pos, conversion_counter};
                CCF_ADDR:         next_rdata = {24'h000000, ccf};
                OPTIONS_ADDR:     next_rdata = {30'h00000000, fast_clear, scan_mode};
                IRQ_STATUS_ADDR:  next_rdata = {30'h00000000, irq_status};
                IRQ_MASK_ADDR:    next_rdata = {30'h00000000, irq_mask};
                default:          next_rdata = 32'h0000_0000;
            endcase
        end
    end

    // ==================================================================
    // writable registers
    // ==================================================================
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seq_ctrl   <= SEQ_CTRL_RESET;
            scan_mode  <= 1'b0;
            fast_clear <= 1'b0;
            irq_mask   <= '0;
        end else if (dp_write) begin
            case (dp_addr)
                SEQ_CTRL_ADDR: seq_ctrl <= hwdata[7:0] & SEQ_CTRL_WMASK;
                OPTIONS_ADDR: begin
                    scan_mode  <= hwdata[SCAN_BIT];
                    fast_clear <= hwdata[FAST_CLEAR_BIT];
                end
                IRQ_MASK_ADDR: irq_mask <= hwdata[IRQ_WIDTH-1:0];
                default: ;
            endcase
        end
    end

    // combinational decode, so a new length applies from the next edge
    seq_len_decode u_len (
        .len_field (seq_ctrl[LEN_MSB:LEN_LSB]),
        .len_count (len_count)
    );

    // ==================================================================
    // freeze input synchroniser
    // ==================================================================
    // only the second flop is read; the first may still be settling
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            freeze_sync1 <= 1'b0;
            freeze_sync2 <= 1'b0;
        end else begin
            freeze_sync1 <= debug_freeze;
            freeze_sync2 <= freeze_sync1;
        end
    end

    // reserved code 01 is treated as continue
    assign freeze_req = freeze_sync2 && seq_ctrl[FREEZE_MSB];
    assign conv_hold  = freeze_req && seq_ctrl[FREEZE_LSB];
    assign seq_last   = seq_pos == len_count - 4'h1;
    // without scanning a sequence ends at its last position
    assign seq_end    = seq_last && !scan_mode;
    // a start write always relaunches the timer, so a restart or a start from
    // the frozen state never leaves the machine waiting on an idle timer
    assign conv_start = start_write ||
                        (state == ST_CONV && conv_done && !seq_end && !freeze_req) ||
                        (state == ST_FROZEN && !freeze_req);

    // a control write cancels the timer, so an aborted conversion stores nothing
    conv_timer u_timer (
        .hclk    (hclk),
        .hresetn (hresetn),
        .start   (conv_start),
        .hold    (conv_hold),
        .cancel  (ctrl_write),
        .done    (conv_done)
    );

    // ==================================================================
    // sequence state machine and conversion counter
    // ==================================================================
    // a control write wins over everything: aborts, clears the counter
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state              <= ST_IDLE;
            conversion_counter <= 3'h0;
            seq_pos            <= 4'h0;
        end else if (ctrl_write) begin
            state              <= ST_IDLE;
            conversion_counter <= 3'h0;
            seq_pos            <= 4'h0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (start_write) begin
                        state              <= ST_CONV;
                        conversion_counter <= 3'h0;
                        seq_pos            <= 4'h0;
                    end
                end
                ST_CONV: begin
                    if (start_write) begin
                        state              <= ST_CONV; // restart
                        conversion_counter <= 3'h0;
                        seq_pos            <= 4'h0;
                    end else if (conv_done) begin
                        // position wraps after the last position of the sequence
                        seq_pos <= seq_last ? 4'h0 : seq_pos + 4'h1;
                        if (seq_ctrl[QUEUE_BIT]) begin
                            conversion_counter <= conversion_counter + 3'h1;
                        end else begin
                            conversion_counter <= seq_last ? 3'h0 : 3'(seq_pos + 4'h1);
                        end
                        if (seq_end) begin
                            state <= ST_IDLE;
                        end else if (freeze_req) begin
                            state <= ST_FROZEN;
                        end
                    end
                end
                ST_FROZEN: begin
                    // a start here relaunches the timer at once
                    if (start_write) begin
                        state              <= ST_CONV;
                        conversion_counter <= 3'h0;
                        seq_pos            <= 4'h0;
                    end else if (!freeze_req) begin
                        state <= ST_CONV;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ==================================================================
    // result file and completion flags
    // ==================================================================
    // fast clear acts on any data phase that touches a result word
    assign result_access = fast_clear && (dp_read || dp_write) && is_result(dp_addr);

    // a completion in the same cycle as a fast clear keeps the flag set
    generate
        for (genvar i = 0; i < NUM_RESULTS; i++) begin : g_res
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    results[i] <= '0;
                    ccf[i]     <= 1'b0;
                end else if (state == ST_CONV && conv_done && !ctrl_write && !start_write &&
                             conversion_counter == 3'(i)) begin
                    results[i] <= sample_data;
                    ccf[i]     <= 1'b1;
                end else if (result_access && dp_addr[4:2] == 3'(i)) begin
                    ccf[i] <= 1'b0;
                end
            end
        end
    endgenerate

    // ==================================================================
    // interrupts
    // ==================================================================
    // write one to clear; a new event in the same cycle wins
    // irq is registered, so it trails the status bits by one cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_status <= '0;
            irq        <= 1'b0;
        end else begin
            irq_status[IRQ_SEQ_DONE] <= (state == ST_CONV && conv_done && seq_last && !ctrl_write) ||
                (irq_status[IRQ_SEQ_DONE] && !(dp_write && dp_addr == IRQ_STATUS_ADDR && hwdata[IRQ_SEQ_DONE]));
            irq_status[IRQ_ABORT] <= (ctrl_write && state != ST_IDLE) ||
                (irq_status[IRQ_ABORT] && !(dp_write && dp_addr == IRQ_STATUS_ADDR && hwdata[IRQ_ABORT]));
            irq <= |(irq_status & irq_mask);
        end
    end

    // ==================================================================
    // converter side outputs
    // ==================================================================
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            converting     <= 1'b0;
            sample_channel <= 3'h0;
        end else begin
            // an immediate freeze stalls the timer, so nothing converts then
            converting     <= state == ST_CONV && !conv_hold;
            sample_channel <= seq_pos[2:0];
        end
    end

endmodule

// [testbench/adc_sequence_control_chk.sv]
`timescale 1ns/1ns
module adc_sequence_control_chk
    import adc_seq_pkg::*;
(
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // bus side
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    input  wire logic        hreadyout,
    input  wire logic        hresp,
    // converter side
    input  wire logic        debug_freeze,
    input  wire logic        converting,
    input  wire logic [2:0]  sample_channel,
    input  wire logic        irq
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // ==================================================================
    // shadow of the control and mask registers
    // ==================================================================
    logic       tk;
    logic       ph_ctrl;
    logic       ph_mask;
    logic [6:0] ctrl_sh;
    logic [1:0] mask_sh;
    logic [3:0] len_n;
    assign tk    = hsel && hready && htrans[1];
    assign len_n = (ctrl_sh[6] || ctrl_sh[6:3] == 4'h0) ? 4'h8 : {1'b0, ctrl_sh[5:3]};

    // data phase is always the next edge, since the slave never stalls
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_ctrl <= 1'b0;
            ph_mask <= 1'b0;
            ctrl_sh <= SEQ_CTRL_RESET[6:0];
            mask_sh <= 2'h0;
        end else begin
            ph_ctrl <= tk && hwrite && haddr == SEQ_CTRL_ADDR;
            ph_mask <= tk && hwrite && haddr == IRQ_MASK_ADDR;
            if (ph_ctrl) ctrl_sh <= hwdata[6:0];
            if (ph_mask) mask_sh <= hwdata[1:0];
        end
    end

    // ==================================================================
    // assertions
    // ==================================================================
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    ctrl_read_a: assert property (tk && !hwrite && haddr == SEQ_CTRL_ADDR && !ph_ctrl
        |=> hrdata == {25'h0, ctrl_sh}) else $error("control readback wrong");
    unmapped_zero_a: assert property (tk && !hwrite && haddr == 8'h04 |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    hrdata_hold_a: assert property (!(tk && !hwrite) |=> $stable(hrdata))
        else $error("read data changed without a read");
    ctrl_abort_a: assert property (tk && hwrite && haddr == SEQ_CTRL_ADDR |-> ##3 !converting)
        else $error("control write did not stop the sequence");
    chan_range_a: assert property (converting && !$past(ph_ctrl) |-> {1'b0, sample_channel} < len_n)
        else $error("position beyond sequence length");
    freeze_now_a: assert property (debug_freeze && ctrl_sh[1:0] == FREEZE_NOW |-> ##[0:6] !converting)
        else $error("immediate freeze did not stop conversion");
    mask_quiet_a: assert property (mask_sh == 2'h0 && $past(mask_sh) == 2'h0 |-> !irq)
        else $error("irq high with all sources masked");

    conv_seen_c: cover property ($rose(converting));
    frozen_c: cover property (debug_freeze && converting ##1 !converting);
    irq_seen_c: cover property ($rose(irq));
endmodule

bind adc_sequence_control adc_sequence_control_chk u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hwdata, .hready, .hrdata, .hreadyout, .hresp, .debug_freeze, .converting, .sample_channel, .irq);

// [testbench/tb_adc_sequence_control.sv]
`timescale 1ns/1ns
module tb_adc_sequence_control
    import adc_seq_pkg::*;
;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    wire  logic  hready;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        debug_freeze;
    logic [9:0]  sample_data;
    logic        converting;
    logic [2:0]  sample_channel;
    logic        irq;
    logic [31:0] seed;
    logic [31:0] v;
    logic [31:0] q;
    int          n_errors;
    int          checks_done;
    int          res_m[8];
    int          flags_m;

    assign hready = hreadyout;
    always #50 hclk = ~hclk;

    adc_sequence_control u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .debug_freeze(debug_freeze), .sample_data(sample_data),
        .converting(converting), .sample_channel(sample_channel), .irq(irq));

    // ==================================================================
    // helpers
    // ==================================================================
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // one single transfer; address held until hready, read data taken at the data-phase edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        bus(1'b0, a, 32'h0, q);
        chk(q, exp, what);
    endtask

    // poll the sticky done flag, then clear it
    task automatic wait_done();
        logic [31:0] r;
        r = 32'h0;
        for (int i = 0; i < 400 && r[0] !== 1'b1; i++) bus(1'b0, IRQ_STATUS_ADDR, 32'h0, r);
        chk(r[0], 32'h1, "sequence done");
        wr(IRQ_STATUS_ADDR, 32'h1);
    endtask

    // compare the result file with the model; fast clear empties the flags as results are read
    task automatic check_file();
        rd_chk(CCF_ADDR, flags_m, "flags");
        for (int k = 0; k < 8; k++) if (flags_m[k]) rd_chk(RESULT_BASE_ADDR + 8'(4 * k), res_m[k], "result");
        flags_m = 0;
        rd_chk(CCF_ADDR, 32'h0, "flags after fast clear");
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ==================================================================
    // tests
    // ==================================================================
    initial begin
        {hclk, hresetn, hsel, haddr, htrans, hwrite, hwdata, debug_freeze, sample_data} = '0;
        hsize = 3'h2;
        seed = 32'h12C7;
        n_errors = 0;
        checks_done = 0;
        flags_m = 0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        rd_chk(SEQ_CTRL_ADDR, 32'h20, "control reset");
        rd_chk(CONV_STATUS_ADDR, 32'h0, "status reset");
        rd_chk(8'h04, 32'h0, "unmapped");
        wr(OPTIONS_ADDR, 32'h2);
        $display("test reset done");
        // every length code, queue off
        for (int f = 0; f < 16; f++) begin
            v = rnd() & 32'h3FF;
            sample_data <= v[9:0];
            wr(SEQ_CTRL_ADDR, f << 3);
            rd_chk(SEQ_CTRL_ADDR, f << 3, "control readback");
            wr(START_ADDR, 32'h1);
            wait_done();
            for (int k = 0; k < ((f == 0 || f > 7) ? 8 : f); k++) begin
                res_m[k] = v;
                flags_m |= 1 << k;
            end
            check_file();
            chk(converting, 32'h0, "stopped at length");
        end
        $display("test length done");
        // queue mode with scanning, aborted by a control write
        wr(IRQ_MASK_ADDR, 32'h2);
        wr(OPTIONS_ADDR, 32'h3);
        wr(SEQ_CTRL_ADDR, 32'h1C);
        wr(START_ADDR, 32'h1);
        repeat (200) @(posedge hclk);
        wr(SEQ_CTRL_ADDR, 32'h1C);
        repeat (2) @(posedge hclk);
        chk(converting, 32'h0, "abort");
        rd_chk(CONV_STATUS_ADDR, 32'h0, "counter after abort");
        for (int k = 0; k < 8; k++) res_m[k] = v;
        flags_m = 32'hFF;
        check_file();
        chk(irq, 32'h1, "abort irq");
        repeat (20) @(posedge hclk);
        chk(converting, 32'h0, "no restart");
        wr(IRQ_MASK_ADDR, 32'h0);
        repeat (2) @(posedge hclk);
        chk(irq, 32'h0, "masked irq");
        wr(IRQ_MASK_ADDR, 32'h2);
        repeat (2) @(posedge hclk);
        chk(irq, 32'h1, "unmasked irq");
        wr(IRQ_STATUS_ADDR, 32'h3);
        repeat (2) @(posedge hclk);
        chk(irq, 32'h0, "cleared irq");
        // a fresh start in queue mode begins at the first register
        wr(OPTIONS_ADDR, 32'h2);
        v = rnd() & 32'h3FF;
        sample_data <= v[9:0];
        wr(START_ADDR, 32'h1);
        wait_done();
        bus(1'b0, CONV_STATUS_ADDR, 32'h0, q);
        chk(q & 32'h7, 32'h3, "counter kept at end");
        for (int k = 0; k < 3; k++) res_m[k] = v;
        flags_m = 32'h7;
        check_file();
        $display("test queue done");
        // every freeze response
        for (int c = 0; c < 4; c++) begin
            v = rnd() & 32'h3FF;
            sample_data <= v[9:0];
            wr(SEQ_CTRL_ADDR, 32'h10 | c);
            wr(START_ADDR, 32'h1);
            repeat (5) @(posedge hclk);
            debug_freeze <= 1'b1;
            repeat (6) @(posedge hclk);
            chk(converting, c != 3, "freeze entry");
            repeat (25) @(posedge hclk);
            rd_chk(CCF_ADDR, c == 2 ? 1 : c == 3 ? 0 : 3, "freeze progress");
            debug_freeze <= 1'b0;
            wait_done();
            res_m[0] = v;
            res_m[1] = v;
            flags_m = 3;
            check_file();
        end
        $display("test freeze done");
        end_of_test();
    end

    // watchdog: the tests need well under 10000 cycles
    initial begin
        #3_000_000;
        n_errors++;
        end_of_test();
    end
endmodule
